//--- hw/mdc_top.v
// Control logic of a serially loaded quad or octal 10-bit DAC:
// serial input register, system and channel control, data and DAC
// registers. Assumes the serial pins and the load strobe come from
// outside the clk domain and are much slower than clk.
`include "mdc_defines.vh"

// Function
// RULE1 - Power-down bit low puts everything low power
// RULE2 - Registers retained while powered down
// RULE3 - One coding bit: 0 twos, 1 offset
// RULE4 - All-channel standby bit idles every DAC
// RULE5 - Global clear empties main data, DAC registers
// RULE6 - Clear gives midscale or bottom per coding
// RULE7 - Global clear leaves trim data untouched
// RULE8 - Address bits pick one channel
// RULE9 - Four channels: top address bit ignored
// RULE10 - Eight channels: all three address bits decoded
// RULE11 - Channel standby low idles addressed DAC only
// RULE12 - Channel clear hits addressed main DAC only
// RULE13 - Host follows channel clear with load strobe
// RULE14 - Two bias bits choose channel bias source
// RULE15 - Top word bit picks trim or main
// RULE16 - Trim holds eight bits, low two ignored
// RULE17 - Trim code follows selected input coding
// RULE18 - Select bits route system, channel or data
// RULE19 - Sample data MSB first on falling clock
// RULE20 - Load strobe low copies all data registers
// RULE21 - Commit only exactly sixteen-bit frames
module mdc_top #(
  parameter NUM_CHANNELS = 8
) (
  input wire clk,
  input wire rst_n,
  input wire frame_sync_n,
  input wire serial_clock_in,
  input wire serial_data_in,
  input wire load_outputs_n,
  output reg reference_on,
  output reg input_coding_select,
  output reg [NUM_CHANNELS-1:0] channel_active,
  output reg [NUM_CHANNELS*2-1:0] bias_select,
  output reg [NUM_CHANNELS*10-1:0] main_dac_code,
  output reg [NUM_CHANNELS*8-1:0] trim_dac_code
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  reg [1:0] fs_sync;
  reg [1:0] sck_sync;
  reg [1:0] sdi_sync;
  reg [1:0] ld_sync;
  reg sck_last;
  reg fs_last;
  reg ld_last;
  wire sck_fall;
  wire frame_end;
  wire frame_start;
  wire load_fall;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      fs_sync <= 2'h3;
      sck_sync <= 2'h3;
      sdi_sync <= 2'h0;
      ld_sync <= 2'h3;
      sck_last <= 1'h1;
      fs_last <= 1'h1;
      ld_last <= 1'h1;
    end
    else
    begin
      fs_sync <= {fs_sync[0], frame_sync_n};
      sck_sync <= {sck_sync[0], serial_clock_in};
      sdi_sync <= {sdi_sync[0], serial_data_in};
      ld_sync <= {ld_sync[0], load_outputs_n};
      sck_last <= sck_sync[1];
      fs_last <= fs_sync[1];
      ld_last <= ld_sync[1];
    end
  end

  assign sck_fall = sck_last & ~sck_sync[1] & ~fs_sync[1]; // [RULE19]
  // Frame edges seen on the synchronised level
  assign frame_start = fs_last & ~fs_sync[1];
  assign frame_end = ~fs_last & fs_sync[1];
  assign load_fall = ld_last & ~ld_sync[1]; // [RULE20]

  // ----------------------------------------------------------------
  // Input shift register
  // ----------------------------------------------------------------
  reg [`MDC_WORD_BITS-1:0] shift_word;
  reg [`MDC_CNT_W-1:0] bit_count;
  reg word_valid;
  reg [`MDC_WORD_BITS-1:0] word;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      shift_word <= 16'h0000;
      bit_count <= 5'h00;
      word_valid <= 1'h0;
      word <= 16'h0000;
    end
    else
    begin
      word_valid <= 1'h0;
      if (frame_end)
      begin
        bit_count <= 5'h00;
        if (bit_count == `MDC_CNT_FULL) // [RULE21]
        begin
          word_valid <= 1'h1;
          word <= shift_word;
        end
      end
      else if (sck_fall)
      begin
        shift_word <= {shift_word[`MDC_WORD_BITS-2:0], sdi_sync[1]}; // [RULE19]
        // A seventeenth bit parks the count at over, so the word is refused
        if (frame_start)
          bit_count <= 5'h01;
        else if (bit_count != `MDC_CNT_OVER)
          bit_count <= bit_count + 5'h01; // [RULE21]
      end
      // Each frame counts from its own start
      else if (frame_start)
        bit_count <= 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  wire register_select_hi;
  wire register_select_lo;
  wire channel_address_hi;
  wire channel_address_mid;
  wire channel_address_lo;
  wire [2:0] channel_addr;
  wire wr_system;
  wire wr_channel;
  wire wr_main;
  wire wr_trim;
  wire [9:0] clear_code;
  wire coding_now;

  assign register_select_hi = word[`MDC_SEL_HI_BIT];
  assign register_select_lo = word[`MDC_SEL_LO_BIT];
  assign channel_address_hi = (NUM_CHANNELS > 4) ? word[`MDC_ADDR_HI_BIT] : 1'h0; // [RULE9] [RULE10]
  assign channel_address_mid = word[`MDC_ADDR_MID_BIT];
  assign channel_address_lo = word[`MDC_ADDR_LO_BIT];
  assign channel_addr = {channel_address_hi, channel_address_mid, channel_address_lo}; // [RULE8]

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  assign wr_system = word_valid & ~register_select_hi & ~register_select_lo; // [RULE18]
  assign wr_channel = word_valid & ~register_select_hi & register_select_lo; // [RULE18]
  assign wr_main = word_valid & register_select_hi & ~word[`MDC_DATA_SEL_BIT]; // [RULE15]
  assign wr_trim = word_valid & register_select_hi & word[`MDC_DATA_SEL_BIT]; // [RULE15]

  // ----------------------------------------------------------------
  // System control register
  // ----------------------------------------------------------------
  reg power_down_n;
  reg all_channel_standby;
  reg global_soft_clear;
  wire global_clear_hit;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      power_down_n <= `MDC_RST_PD_N;
      input_coding_select <= `MDC_RST_CODING;
      all_channel_standby <= `MDC_RST_ALL_CHANNEL_STANDBY_N;
      global_soft_clear <= `MDC_RST_GCLEAR;
    end
    else if (wr_system)
    begin
      power_down_n <= word[`MDC_SYS_PD_N_BIT]; // [RULE1]
      input_coding_select <= word[`MDC_SYS_CODING_BIT]; // [RULE3]
      all_channel_standby <= word[`MDC_SYS_CHANNEL_STANDBY_N_BIT]; // [RULE4]
      global_soft_clear <= word[`MDC_SYS_CLEAR_BIT]; // [RULE5]
    end
  end

  // Clearing acts on the write itself; the bit is kept for reference
  assign global_clear_hit = wr_system & word[`MDC_SYS_CLEAR_BIT]; // [RULE5]

  // ----------------------------------------------------------------
  // Clear code
  // ----------------------------------------------------------------
  // A write that clears and recodes at once uses its new coding
  assign coding_now = wr_system ? word[`MDC_SYS_CODING_BIT] : input_coding_select; // [RULE3] [RULE6]
  // Zero is midscale in twos complement and bottom in offset binary
  assign clear_code = coding_now ? `MDC_CLEAR_OFFSET : `MDC_CLEAR_TWOS; // [RULE6]

  always @(posedge clk)
  begin
    if (!rst_n)
      reference_on <= `MDC_RST_PD_N;
    else
      reference_on <= power_down_n; // [RULE1]
  end

  // ----------------------------------------------------------------
  // Per-channel control, data and DAC registers
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1)
    begin : g_chan
      reg channel_standby_n;
      reg channel_soft_clear;
      reg bias_source_hi;
      reg bias_source_lo;
      reg [9:0] main_data;
      reg [7:0] trim_data;
      wire hit;

      // Channel select, widened to compare against the loop index
      assign hit = ({29'h0, channel_addr} == ch); // [RULE8]

      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          channel_standby_n <= `MDC_RST_CHANNEL_STANDBY_N_N;
          channel_soft_clear <= `MDC_RST_CH_CLEAR;
          {bias_source_hi, bias_source_lo} <= `MDC_RST_BIAS;
        end
        else if (wr_channel && hit)
        begin
          channel_standby_n <= word[`MDC_CH_CHANNEL_STANDBY_N_N_BIT]; // [RULE11]
          channel_soft_clear <= word[`MDC_CH_CLEAR_BIT]; // [RULE12]
          bias_source_hi <= word[`MDC_CH_BIAS_HI_BIT]; // [RULE14]
          bias_source_lo <= word[`MDC_CH_BIAS_LO_BIT]; // [RULE14]
        end
      end

      // Data registers keep their values through power down
      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          main_data <= `MDC_RST_MAIN;
          trim_data <= `MDC_RST_TRIM;
        end
        else
        begin
          if (global_clear_hit)
            main_data <= clear_code; // [RULE5] [RULE7]
          else if (wr_main && hit)
            main_data <= word[`MDC_MAIN_HI_BIT:`MDC_MAIN_LO_BIT]; // [RULE2]
          if (wr_trim && hit)
            trim_data <= word[`MDC_TRIM_HI_BIT:`MDC_TRIM_LO_BIT]; // [RULE16]
        end
      end

      // DAC registers, loaded together on the strobe
      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          main_dac_code[ch*10 +: 10] <= `MDC_RST_MAIN;
          trim_dac_code[ch*8 +: 8] <= `MDC_RST_TRIM;
        end
        else
        begin
          if (global_clear_hit)
            main_dac_code[ch*10 +: 10] <= clear_code; // [RULE5] [RULE6]
          else if (load_fall && channel_soft_clear)
            main_dac_code[ch*10 +: 10] <= clear_code; // [RULE12] [RULE13]
          else if (load_fall)
            main_dac_code[ch*10 +: 10] <= main_data; // [RULE20]
          // Trim code is passed raw; coding selects how it is read
          if (load_fall)
            trim_dac_code[ch*8 +: 8] <= trim_data; // [RULE17] [RULE20]
        end
      end

      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          channel_active[ch] <= 1'h0;
          bias_select[ch*2 +: 2] <= `MDC_RST_BIAS;
        end
        else
        begin
          channel_active[ch] <= power_down_n & ~all_channel_standby & channel_standby_n; // [RULE1] [RULE4] [RULE11]
          bias_select[ch*2 +: 2] <= {bias_source_hi, bias_source_lo}; // [RULE14]
        end
      end
    end
  endgenerate

endmodule

//--- hw/mdc_defines.vh
// Constants for the multi-DAC control block: serial word layout,
// register fields, reset values and clear codes.
// Assumes inclusion by bare name from the design file.
`ifndef MDC_DEFINES_VH
`define MDC_DEFINES_VH

// ----------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------
`define MDC_WORD_BITS 16
`define MDC_CNT_W 5
`define MDC_CNT_FULL 5'h10
`define MDC_CNT_OVER 5'h11
`define MDC_DATA_SEL_BIT 15
`define MDC_SEL_LO_BIT 14
`define MDC_SEL_HI_BIT 13
`define MDC_ADDR_HI_BIT 12
`define MDC_ADDR_LO_BIT 10
`define MDC_ADDR_MID_BIT 11

// ----------------------------------------------------------------
// System control fields
// ----------------------------------------------------------------
`define MDC_SYS_CODING_BIT 6
`define MDC_SYS_PD_N_BIT 5
`define MDC_SYS_CHANNEL_STANDBY_N_BIT 4
`define MDC_SYS_CLEAR_BIT 3

// ----------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------
`define MDC_CH_BIAS_HI_BIT 9
`define MDC_CH_BIAS_LO_BIT 8
`define MDC_CH_CHANNEL_STANDBY_N_N_BIT 4
`define MDC_CH_CLEAR_BIT 3

// ----------------------------------------------------------------
// Data fields
// ----------------------------------------------------------------
`define MDC_MAIN_HI_BIT 9
`define MDC_MAIN_LO_BIT 0
`define MDC_TRIM_HI_BIT 9
`define MDC_TRIM_LO_BIT 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MDC_RST_PD_N 1'h1
`define MDC_RST_ALL_CHANNEL_STANDBY_N 1'h1
`define MDC_RST_CODING 1'h0
`define MDC_RST_GCLEAR 1'h0
`define MDC_RST_CHANNEL_STANDBY_N_N 1'h1
`define MDC_RST_CH_CLEAR 1'h1
`define MDC_RST_BIAS 2'h0
`define MDC_RST_MAIN 10'h000
`define MDC_RST_TRIM 8'h00

// ----------------------------------------------------------------
// Clear codes: midscale in twos complement, bottom in offset binary
// ----------------------------------------------------------------
`define MDC_CLEAR_TWOS 10'h000
`define MDC_CLEAR_OFFSET 10'h000

`endif

//--- testbench/mdc_top_assertions.sv
// Checker for the multi-DAC control block, bound to its top module.
// Assumes the serial host leaves frame sync high for at least 15 clk.
module mdc_top_assertions #(
  parameter NUM_CHANNELS = 8
) (
  input wire clk,
  input wire rst_n,
  input wire frame_sync_n,
  input wire load_outputs_n,
  input wire reference_on,
  input wire input_coding_select,
  input wire [NUM_CHANNELS-1:0] channel_active,
  input wire [NUM_CHANNELS*2-1:0] bias_select,
  input wire [NUM_CHANNELS*10-1:0] main_dac_code,
  input wire [NUM_CHANNELS*8-1:0] trim_dac_code
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------
  // Ages since frame end and load
  // ------------------------------
  reg fs_q;
  reg ld_q;
  reg [3:0] fs_age;
  reg [3:0] ld_age;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      fs_q <= 1'b1;
      ld_q <= 1'b1;
      fs_age <= 4'hf;
      ld_age <= 4'hf;
    end
    else
    begin
      fs_q <= frame_sync_n;
      ld_q <= load_outputs_n;
      fs_age <= (frame_sync_n && !fs_q) ? 4'h0 : ((fs_age == 4'hf) ? fs_age : fs_age + 4'h1);
      ld_age <= (!load_outputs_n && ld_q) ? 4'h0 : ((ld_age == 4'hf) ? ld_age : ld_age + 4'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_coding_after_frame: assert property ($changed(input_coding_select) |-> frame_sync_n && fs_age <= 4'ha)
    else $error("coding changed outside a frame end");
  a_ref_after_frame: assert property ($changed(reference_on) |-> fs_age <= 4'ha)
    else $error("reference changed outside a frame end");
  a_pd_all_idle: assert property (!reference_on |-> channel_active == '0)
    else $error("channel active while powered down");
  a_bias_after_frame: assert property ($changed(bias_select) |-> frame_sync_n && fs_age <= 4'ha)
    else $error("bias changed outside a frame end");
  a_active_after_frame: assert property ($changed(channel_active) |-> $past(frame_sync_n) && fs_age <= 4'ha)
    else $error("standby changed outside a frame end");
  a_trim_on_load: assert property ($changed(trim_dac_code) |-> ld_age <= 4'h8)
    else $error("trim code changed without load strobe");
  a_main_cause: assert property ($changed(main_dac_code) |-> ld_age <= 4'h8 || fs_age <= 4'ha)
    else $error("main code changed without cause");
  a_frame_quiet: assert property ((!frame_sync_n && fs_age == 4'hf) [*2] |-> $stable(bias_select))
    else $error("register changed inside a frame");
  c_power_down: cover property ($fell(reference_on));
  c_trim_load: cover property ($changed(trim_dac_code));
  c_all_active: cover property (&channel_active);
endmodule

bind mdc_top mdc_top_assertions #(.NUM_CHANNELS(NUM_CHANNELS)) u_mdc_top_assertions (
  .clk(clk),
  .rst_n(rst_n),
  .frame_sync_n(frame_sync_n),
  .load_outputs_n(load_outputs_n),
  .reference_on(reference_on),
  .input_coding_select(input_coding_select),
  .channel_active(channel_active),
  .bias_select(bias_select),
  .main_dac_code(main_dac_code),
  .trim_dac_code(trim_dac_code)
);

//--- testbench/mdc_host.sv
// Serial host model: shifts words MSB first, data taken on falling clock.
// Assumes the bench calls send; serial clock rests high between frames.
module mdc_host (
  input wire clk,
  output logic frame_sync_n,
  output logic serial_clock_in,
  output logic serial_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    frame_sync_n = 1'b1;
    serial_clock_in = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    @(negedge clk);
    frame_sync_n = 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      serial_data_in = w[i];
      #62.5 serial_clock_in = 1'b0;
      #62.5 serial_clock_in = 1'b1;
    end
    frame_sync_n = 1'b1;
    // Released data line shows the inverse of its last bit
    serial_data_in = ~serial_data_in;
    repeat (15) @(negedge clk);
  endtask
endmodule

//--- testbench/multi_dac_control_registers_tb.sv
// Self-checking bench for the multi-DAC control block, eight channels.
// Assumes the host model and the bound checker are compiled alongside.
module multi_dac_control_registers_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic load_outputs_n = 1'b1;
  wire frame_sync_n, serial_clock_in, serial_data_in, reference_on, input_coding_select;
  wire [7:0] channel_active;
  wire [15:0] bias_select;
  wire [79:0] main_dac_code;
  wire [63:0] trim_dac_code;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 23;
  logic coding = 1'b0, ref_on = 1'b1, all_channel_standby_n = 1'b1;
  logic [7:0] channel_standby_n_n = 8'hff, clr = 8'hff;
  logic [1:0] bias [8];
  logic [9:0] data [8], dac [8];
  logic [7:0] tdata [8], tdac [8];
  always #5 clk = ~clk;
  mdc_host u_mdc_host (.clk(clk), .frame_sync_n(frame_sync_n), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in));
  mdc_top #(.NUM_CHANNELS(8)) u_mdc_top (.clk(clk), .rst_n(rst_n), .frame_sync_n(frame_sync_n),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in), .load_outputs_n(load_outputs_n),
    .reference_on(reference_on), .input_coding_select(input_coding_select), .channel_active(channel_active),
    .bias_select(bias_select), .main_dac_code(main_dac_code), .trim_dac_code(trim_dac_code));
  task results;
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmp(input logic [79:0] got, input logic [79:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic act(int c);
    return ref_on && !all_channel_standby_n && channel_standby_n_n[c];
  endfunction
  task check_all;
    logic [79:0] m;
    logic [63:0] t;
    logic [15:0] b;
    logic [7:0] a;
    for (int c = 0; c < 8; c++)
    begin
      m[c*10+:10] = dac[c];
      t[c*8+:8] = tdac[c];
      b[c*2+:2] = bias[c];
      a[c] = act(c);
    end
    cmp(80'(reference_on), 80'(ref_on));
    cmp(80'(input_coding_select), 80'(coding));
    cmp(80'(channel_active), 80'(a));
    cmp(80'(bias_select), 80'(b));
    cmp(main_dac_code, m);
    cmp(80'(trim_dac_code), 80'(t));
  endtask
  task sys(input logic cd, pd, sb, gc);
    u_mdc_host.send({9'h000, cd, pd, sb, gc, 3'h0}, 16);
    {coding, ref_on, all_channel_standby_n} = {cd, pd, sb};
    for (int c = 0; c < 8; c++)
      if (gc)
        {dac[c], data[c]} = 20'h00000;
  endtask
  task chw(input int c, input logic [1:0] bs, input logic sn, cl);
    u_mdc_host.send({3'b010, 3'(c), bs, 3'h0, sn, cl, 3'h0}, 16);
    {bias[c], channel_standby_n_n[c], clr[c]} = {bs, sn, cl};
  endtask
  task dw(input int c, input logic sub, input logic [9:0] v);
    u_mdc_host.send({sub, 1'($random(seed)), 1'b1, 3'(c), v}, 16);
    if (sub)
      tdata[c] = v[9:2];
    else
      data[c] = v;
  endtask
  task load;
    @(negedge clk) load_outputs_n = 1'b0;
    repeat (6) @(negedge clk);
    load_outputs_n = 1'b1;
    repeat (10) @(negedge clk);
    for (int c = 0; c < 8; c++)
      {dac[c], tdac[c]} = {clr[c] ? 10'h000 : data[c], tdata[c]};
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    results;
  end
  initial
  begin
    for (int c = 0; c < 8; c++)
      {bias[c], data[c], dac[c], tdata[c], tdac[c]} = 38'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check_all;
    sys(1'($random(seed)), 1'b1, 1'b0, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      chw(c, 2'($random(seed)), 1'b1, 1'b0);
      dw(c, 1'b0, 10'($random(seed)));
      dw(c, 1'b1, 10'($random(seed)));
    end
    check_all;
    load;
    check_all;
    u_mdc_host.send(16'h0000, 15);
    check_all;
    chw(5, bias[5], 1'b0, 1'b0);
    check_all;
    sys(coding, 1'b1, 1'b1, 1'b0);
    check_all;
    sys(coding, 1'b0, 1'b0, 1'b0);
    check_all;
    sys(coding, 1'b1, 1'b0, 1'b0);
    check_all;
    chw(3, bias[3], 1'b1, 1'b1);
    check_all;
    load;
    check_all;
    chw(3, bias[3], 1'b1, 1'b0);
    load;
    check_all;
    sys(~coding, 1'b1, 1'b0, 1'b1);
    check_all;
    results;
  end
endmodule
